// ==== rtl/plce_pkg.sv ====
// shared constants and types for the port local command executor
package plce_pkg;
  // operation code word layout
  localparam int          OPC_LSB       = 0;
  localparam int          OPC_W         = 8;
  localparam int          RSP_BIT       = 8;
  localparam int          CLR_BIT       = 9;
  localparam int          STS_LSB       = 16;
  // opcodes handled here
  localparam logic [7:0]  OP_RD_CNT     = 8'h04;
  localparam logic [7:0]  OP_DG_RCV     = 8'h05;
  localparam logic [7:0]  OP_WR_LINK    = 8'h06;
  localparam logic [7:0]  OP_RD_LINK    = 8'h07;
  localparam logic [7:0]  OP_RD_STA     = 8'h08;
  localparam logic [7:0]  OP_WR_STA     = 8'h09;
  // fixed counts
  localparam int          HDR_WORDS     = 4;
  localparam int          CNT_WORDS     = 44;
  localparam logic [11:0] HALT_LOC      = 12'hFE8;  // microcode location octal 7750
  localparam logic [7:0]  VERSION       = 8'h01;    // arbitrary value
  // register port offsets
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_MASK      = 8'h04;
  localparam logic [7:0]  REG_CTRL      = 8'h08;
  localparam logic [7:0]  REG_FLAGS     = 8'h0C;
  localparam logic [7:0]  REG_STA_LO    = 8'h10;
  localparam logic [7:0]  REG_STA_HI    = 8'h14;
  // interrupt status bits
  localparam int          IRQ_RSP       = 0;
  localparam int          IRQ_HALT      = 1;
  localparam int          IRQ_DONE      = 2;
  localparam int          IRQ_N         = 3;
  // control bits and reset values
  localparam int          CTRL_EN       = 0;
  localparam int          CTRL_UNHALT   = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam logic [7:0]  MODE_RST      = 8'h00;

  typedef struct packed {
    logic [31:0] opword;
    logic [31:0] link_word;
    logic [47:0] sta_addr;
    logic [7:0]  mode;
    logic [3:0]  retry;
  } plce_cmd_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } plce_reg_req_t;
endpackage : plce_pkg

// ==== rtl/plce_top.sv ====
// port local command executor: counters, link interface and station address commands
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module plce_top #(
  parameter int DW      = 32,
  parameter int N_CNT   = plce_pkg::CNT_WORDS
) (
  input  wire logic                   clk,            // 50 MHz clock
  input  wire logic                   rst,            // synchronous reset, active high
  input  wire plce_pkg::plce_reg_req_t reg_req,       // register port request
  output logic [31:0]                 reg_rdata,      // read data, cycle after read strobe
  output logic                        irq,            // level interrupt
  input  wire logic                   cmd_valid,      // queued command present
  input  wire plce_pkg::plce_cmd_t    cmd,            // queued command
  output logic                        cmd_ready,      // command taken when valid and ready
  input  wire logic                   cnt_inc,        // network counter increment pulse
  input  wire logic [5:0]             cnt_idx,        // counter to increment
  output logic                        chan_start,     // host_channel_bus start pulse
  output logic [31:0]                 channel_command_word, // word count of transfer
  output logic                        host_wr_valid,  // word to host memory valid
  output logic [DW-1:0]               host_wr_data,   // word to host memory
  input  wire logic                   host_wr_ready,  // host memory takes word
  output logic                        link_go,        // port_link_interface execute pulse
  output logic                        link_read,      // link function is a read
  output logic [31:0]                 link_cmd,       // link command word
  input  wire logic                   link_done,      // link function finished pulse
  input  wire logic [31:0]            link_rdata,     // link read result
  output logic                        pa_wr,          // physical address RAM write pulse
  output logic [47:0]                 pa_addr,        // station address
  output logic [7:0]                  mode_bits,      // current mode bits
  output logic [3:0]                  retry_count,    // current retry count
  output logic                        cache_wr,       // store opcode word in cache pulse
  output logic [31:0]                 cache_word,     // completed opcode word
  output logic                        cache_flush,    // flush command cache pulse
  output logic                        rspq_req,       // link response request, held until ack
  input  wire logic                   rspq_ack,       // response linked pulse
  input  wire logic                   rspq_was_empty, // queue was empty, with ack
  output logic                        halted,         // port halted
  output logic [11:0]                 halt_loc        // halt location
);

  if (N_CNT < 1 || N_CNT > 64 || DW != 32) begin : g_bad_param
    $error("N_CNT or DW out of range");
  end

  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_DISP  = 11'h002,
    S_LINK  = 11'h004,
    S_HDR   = 11'h008,
    S_CCW   = 11'h010,
    S_CNT   = 11'h020,
    S_CLR   = 11'h040,
    S_BODY  = 11'h080,
    S_CACHE = 11'h100,
    S_RSPQ  = 11'h200,
    S_HALT  = 11'h400
  } plce_state_t;

  plce_state_t         state_q;
  plce_pkg::plce_cmd_t cmd_q;
  logic [7:0]          op_q;
  logic                active_q, clr_req_q, bldrsp_q;
  logic [5:0]          idx_q;
  logic [1:0]          body_n_q;
  logic [31:0]         link_res_q;
  logic [DW-1:0]       cnt_mem [N_CNT];
  localparam int IRQ_N = plce_pkg::IRQ_N;
  logic [IRQ_N-1:0]    sts_q, mask_q;
  logic [1:0]          ctrl_q;
  logic                rsp_evt, halt_evt, done_evt;

  function automatic logic [7:0] opc(input logic [31:0] w);
    opc = w[plce_pkg::OPC_LSB +: plce_pkg::OPC_W];
  endfunction

  function automatic logic has_resp(input logic [7:0] o, input logic b);
    // read counters and read station address always answer
    has_resp = b || o == plce_pkg::OP_RD_CNT || o == plce_pkg::OP_RD_STA;
  endfunction

  wire logic take    = cmd_valid && cmd_ready;
  wire logic wr_beat = host_wr_valid && host_wr_ready;

  // word presented in body phase
  logic [31:0] body_word;
  always_comb begin
    body_word = 32'h0000_0000;
    unique case (op_q)
      plce_pkg::OP_WR_LINK: body_word = cmd_q.link_word;
      plce_pkg::OP_RD_LINK: body_word = link_res_q;
      default: begin
        unique case (body_n_q)
          2'h0: body_word = {16'h0000, pa_addr[47:32]};
          2'h1: body_word = pa_addr[31:0];
          default: body_word = {16'h0000, mode_bits, plce_pkg::VERSION};
        endcase
      end
    endcase
  end

  // main sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= S_IDLE;
      idx_q    <= 6'h00;
      body_n_q <= 2'h0;
    end else begin
      unique case (state_q)
        S_IDLE: if (take) state_q <= S_DISP;
        S_DISP: begin
          idx_q <= 6'h00;
          unique case (op_q)
            plce_pkg::OP_RD_CNT, plce_pkg::OP_RD_STA: state_q <= S_HDR;
            plce_pkg::OP_DG_RCV: state_q <= S_HALT;
            plce_pkg::OP_WR_LINK, plce_pkg::OP_RD_LINK: state_q <= S_LINK;
            plce_pkg::OP_WR_STA: state_q <= bldrsp_q ? S_HDR : S_IDLE;
            default: state_q <= S_IDLE;
          endcase
        end
        S_LINK: if (link_done) state_q <= bldrsp_q ? S_HDR : S_IDLE;
        S_HDR: if (wr_beat && idx_q == 6'(plce_pkg::HDR_WORDS - 1)) begin
          idx_q    <= 6'h00;
          body_n_q <= 2'h0;
          state_q  <= (op_q == plce_pkg::OP_RD_CNT) ? S_CCW : S_BODY;
        end else if (wr_beat) begin
          idx_q <= idx_q + 6'h01;
        end
        S_CCW: state_q <= S_CNT;
        S_CNT: if (wr_beat && idx_q == 6'(N_CNT - 1)) begin
          state_q <= clr_req_q ? S_CLR : S_CACHE;
        end else if (wr_beat) begin
          idx_q <= idx_q + 6'h01;
        end
        S_CLR: state_q <= S_CACHE;
        S_BODY: if (wr_beat) begin
          body_n_q <= body_n_q + 2'h1;
          if (op_q == plce_pkg::OP_WR_LINK || op_q == plce_pkg::OP_RD_LINK ||
              (op_q == plce_pkg::OP_WR_STA && body_n_q == 2'h1) || body_n_q == 2'h2)
            state_q <= S_CACHE;
        end
        S_CACHE: state_q <= S_RSPQ;
        S_RSPQ: if (rspq_ack) state_q <= S_IDLE;
        S_HALT: if (ctrl_q[plce_pkg::CTRL_UNHALT]) state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // command capture and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q     <= '0;
      op_q      <= 8'h00;
      bldrsp_q  <= 1'b0;
      clr_req_q <= 1'b0;
      active_q  <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      cmd_ready <= (state_q == S_IDLE) && !take && ctrl_q[plce_pkg::CTRL_EN];
      if (take) begin
        cmd_q    <= cmd;
        op_q     <= opc(cmd.opword);
        bldrsp_q <= cmd.opword[plce_pkg::RSP_BIT];
      end
      if (state_q == S_DISP) begin
        if (op_q == plce_pkg::OP_RD_CNT || op_q == plce_pkg::OP_WR_LINK ||
            op_q == plce_pkg::OP_RD_LINK)
          active_q <= 1'b1;
        if (op_q == plce_pkg::OP_RD_CNT)
          clr_req_q <= cmd_q.opword[plce_pkg::CLR_BIT];
      end
      if (state_q == S_CLR || (state_q == S_CNT && wr_beat && idx_q == 6'(N_CNT - 1) && !clr_req_q)) begin
        active_q  <= 1'b0;
        clr_req_q <= 1'b0;
      end
      if ((state_q == S_LINK && link_done) || (state_q == S_BODY && wr_beat))
        active_q <= 1'b0;
    end
  end

  // counters in local store; the clear wipes them in one cycle after readout
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < N_CNT; i++) cnt_mem[i] <= '0;
    end else if (state_q == S_CLR) begin
      for (int i = 0; i < N_CNT; i++) cnt_mem[i] <= '0;
    end else if (cnt_inc && int'(cnt_idx) < N_CNT) begin
      cnt_mem[cnt_idx] <= cnt_mem[cnt_idx] + DW'(1);
    end
  end

  // host channel bus writes; data holds until the host takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      host_wr_valid        <= 1'b0;
      host_wr_data         <= '0;
      chan_start           <= 1'b0;
      channel_command_word <= 32'h0000_0000;
    end else begin
      chan_start <= state_q == S_CCW;
      if (state_q == S_CCW) channel_command_word <= 32'(N_CNT);
      if (!host_wr_valid || host_wr_ready) begin
        host_wr_valid <= 1'b0;
        unique case (state_q)
          S_HDR: if (!(wr_beat && idx_q == 6'(plce_pkg::HDR_WORDS - 1))) begin
            host_wr_valid <= 1'b1;
            host_wr_data  <= (idx_q + (wr_beat ? 6'h01 : 6'h00) == 6'(plce_pkg::HDR_WORDS - 1))
                             ? cmd_q.opword : '0;
          end
          S_CNT: if (!(wr_beat && idx_q == 6'(N_CNT - 1))) begin
            host_wr_valid <= 1'b1;
            host_wr_data  <= cnt_mem[wr_beat ? idx_q + 6'h01 : idx_q];
          end
          S_BODY: if (!wr_beat) begin
            host_wr_valid <= 1'b1;
            host_wr_data  <= body_word;
          end
          default: ;
        endcase
      end
    end
  end

  // link interface, station address, cache and response queue
  always_ff @(posedge clk) begin
    if (rst) begin
      link_go     <= 1'b0;
      link_read   <= 1'b0;
      link_cmd    <= 32'h0000_0000;
      link_res_q  <= 32'h0000_0000;
      pa_wr       <= 1'b0;
      pa_addr     <= 48'h0000_0000_0000;
      mode_bits   <= plce_pkg::MODE_RST;
      retry_count <= 4'h0;
      cache_wr    <= 1'b0;
      cache_word  <= 32'h0000_0000;
      cache_flush <= 1'b0;
      rspq_req    <= 1'b0;
    end else begin
      link_go     <= 1'b0;
      pa_wr       <= 1'b0;
      cache_wr    <= 1'b0;
      cache_flush <= 1'b0;
      if (state_q == S_DISP && (op_q == plce_pkg::OP_WR_LINK || op_q == plce_pkg::OP_RD_LINK)) begin
        link_go   <= 1'b1;
        link_cmd  <= cmd_q.link_word;
        link_read <= op_q == plce_pkg::OP_RD_LINK;
      end
      if (state_q == S_LINK && link_done) begin
        link_res_q  <= link_read ? link_rdata : cmd_q.link_word;
        cache_flush <= !bldrsp_q;
      end
      if (state_q == S_DISP && op_q == plce_pkg::OP_WR_STA) begin
        pa_wr       <= 1'b1;
        pa_addr     <= cmd_q.sta_addr;
        mode_bits   <= cmd_q.mode;
        retry_count <= cmd_q.retry;
        cache_flush <= !bldrsp_q;
      end
      if (state_q == S_DISP && !has_resp(op_q, bldrsp_q) && op_q != plce_pkg::OP_DG_RCV &&
          op_q != plce_pkg::OP_WR_LINK && op_q != plce_pkg::OP_RD_LINK && op_q != plce_pkg::OP_WR_STA)
        cache_flush <= 1'b1;
      if (state_q == S_CACHE) begin
        cache_wr   <= 1'b1;
        cache_word <= cmd_q.opword;
        rspq_req   <= 1'b1;
      end
      if (state_q == S_RSPQ && rspq_ack) rspq_req <= 1'b0;
    end
  end

  assign rsp_evt  = state_q == S_RSPQ && rspq_ack && rspq_was_empty;
  assign halt_evt = state_q == S_DISP && op_q == plce_pkg::OP_DG_RCV;
  assign done_evt = state_q == S_RSPQ && rspq_ack;

  // halt indication
  always_ff @(posedge clk) begin
    if (rst) begin
      halted   <= 1'b0;
      halt_loc <= 12'h000;
    end else if (halt_evt) begin
      halted   <= 1'b1;
      halt_loc <= plce_pkg::HALT_LOC;
    end else if (state_q == S_HALT && ctrl_q[plce_pkg::CTRL_UNHALT]) begin
      halted <= 1'b0;
    end
  end

  // register port, sticky status with write-one-to-clear; a new event wins over the clear
  wire logic [IRQ_N-1:0] evts = {done_evt, halt_evt, rsp_evt};
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_q     <= '0;
      mask_q    <= '0;
      ctrl_q    <= plce_pkg::CTRL_RST;
      reg_rdata <= 32'h0000_0000;
      irq       <= 1'b0;
    end else begin
      ctrl_q[plce_pkg::CTRL_UNHALT] <= 1'b0;
      if (reg_req.wr) begin
        unique case (reg_req.addr)
          plce_pkg::REG_STATUS: sts_q <= (sts_q & ~reg_req.wdata[IRQ_N-1:0]) | evts;
          plce_pkg::REG_MASK:   mask_q <= reg_req.wdata[IRQ_N-1:0];
          plce_pkg::REG_CTRL:   ctrl_q <= reg_req.wdata[1:0];
          default: ;
        endcase
      end
      if (!(reg_req.wr && reg_req.addr == plce_pkg::REG_STATUS)) sts_q <= sts_q | evts;
      irq       <= |(sts_q & mask_q);
      reg_rdata <= 32'h0000_0000;
      if (reg_req.rd) begin
        unique case (reg_req.addr)
          plce_pkg::REG_STATUS: reg_rdata <= 32'(sts_q);
          plce_pkg::REG_MASK:   reg_rdata <= 32'(mask_q);
          plce_pkg::REG_CTRL:   reg_rdata <= 32'(ctrl_q);
          plce_pkg::REG_FLAGS:  reg_rdata <= {8'h00, op_q, 5'h00, state_q};
          plce_pkg::REG_STA_LO: reg_rdata <= pa_addr[31:0];
          plce_pkg::REG_STA_HI: reg_rdata <= {mode_bits, 4'h0, retry_count, pa_addr[47:32]};
          default: reg_rdata <= 32'h0000_0000;
        endcase
        if (reg_req.addr == plce_pkg::REG_FLAGS)
          reg_rdata[10:8] <= {bldrsp_q, clr_req_q, active_q};
        if (reg_req.addr == plce_pkg::REG_FLAGS)
          reg_rdata[11] <= halted;
      end
    end
  end

endmodule : plce_top
`default_nettype wire

// ==== sim/plce_host_model.sv ====
// host memory, response queue and link function model facing the executor
`timescale 1ns/100ps
`default_nettype none
module plce_host_model (
  input  wire logic        clk,       // clock
  input  wire logic        rst,       // reset
  input  wire logic        slow,      // random stalls
  input  wire logic        q_empty,   // queue empty
  input  wire logic        wr_valid,  // word offered
  input  wire logic [31:0] wr_data,   // word
  output logic             wr_ready,  // word taken
  input  wire logic        go,        // link start
  input  wire logic [31:0] lcmd,      // link word
  output logic             done,      // link done
  output logic [31:0]      rdata,     // link result
  input  wire logic        req,       // link request
  output logic             ack,       // linked
  output logic             was_empty  // queue was empty
);
  logic [31:0] words[$];
  logic [15:0] lf_q;
  logic [3:0]  wait_q;
  logic        busy_q;
  always_ff @(posedge clk) begin
    lf_q <= rst ? 16'hACE1 : {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
    wr_ready <= !rst && (!slow || lf_q[2]);
    if (wr_valid && wr_ready) begin
      words.push_back(wr_data);
    end
    // one ack per request; the flag is only meaningful beside it
    ack <= !rst && req && !ack && (!slow || lf_q[5]);
    was_empty <= (req && !ack) ? q_empty : !q_empty;
    done <= 1'b0;
    // the result does not linger: it toggles outside the done pulse
    rdata <= ~rdata;
    if (rst) begin
      busy_q <= 1'b0;
      rdata <= 32'h0;
    end else if (go) begin
      busy_q <= 1'b1;
      wait_q <= slow ? 4'h9 : 4'h0;
    end else if (busy_q) begin
      if (wait_q == 4'h0) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        rdata <= lcmd ^ 32'hA5A5_A5A5;
      end else begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : plce_host_model
`default_nettype wire

// ==== sim/plce_asserts.sv ====
// concurrent checks on the command executor ports
`timescale 1ns/100ps
`default_nettype none
module plce_asserts #(
  parameter int N_CNT = plce_pkg::CNT_WORDS
) (
  input wire logic                clk,                  // clock
  input wire logic                rst,                  // reset
  input wire logic                cmd_valid,            // command present
  input wire plce_pkg::plce_cmd_t cmd,                  // command
  input wire logic                cmd_ready,            // command taken
  input wire logic                chan_start,           // bus start
  input wire logic [31:0]         channel_command_word, // word count
  input wire logic                host_wr_valid,        // host word valid
  input wire logic [31:0]         host_wr_data,         // host word
  input wire logic                host_wr_ready,        // host takes word
  input wire logic                link_go,              // link start
  input wire logic                pa_wr,                // address load
  input wire logic                cache_wr,             // opcode cached
  input wire logic                rspq_req,             // link request
  input wire logic                rspq_ack,             // linked
  input wire logic                halted,               // halted
  input wire logic [11:0]         halt_loc              // halt location
);
  logic       take;
  logic       run_q;
  logic [7:0] op;
  int         hdr_q;
  int         dat_q;
  assign take = cmd_valid && cmd_ready;
  assign op   = cmd.opword[7:0];
  // beats are split at the bus start so header and counter lengths are checked apart
  always_ff @(posedge clk) begin
    if (rst || take) begin
      run_q <= 1'b0;
      hdr_q <= 0;
      dat_q <= 0;
    end else begin
      if (chan_start) run_q <= 1'b1;
      if (host_wr_valid && host_wr_ready && (run_q || chan_start)) dat_q <= dat_q + 1;
      if (host_wr_valid && host_wr_ready && !run_q && !chan_start) hdr_q <= hdr_q + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_TAKE_DROP: assert property (take |=> !cmd_ready)
    else $error("ready stayed high after a take");
  AST_HDR_FIRST: assert property (chan_start |-> hdr_q == plce_pkg::HDR_WORDS)
    else $error("header length wrong at bus start");
  AST_CCW_LEN: assert property (chan_start |-> channel_command_word == N_CNT)
    else $error("channel command word wrong");
  AST_CNT_LEN: assert property (cache_wr && run_q |-> dat_q == N_CNT)
    else $error("counter word count wrong");
  AST_WORD_HOLD: assert property (host_wr_valid && !host_wr_ready |=> host_wr_valid && $stable(host_wr_data))
    else $error("host word dropped before taken");
  AST_RSP_HOLD: assert property (rspq_req && !rspq_ack |=> rspq_req)
    else $error("response request dropped early");
  AST_DG_HALT: assert property (take && op == plce_pkg::OP_DG_RCV |-> ##[1:4] (halted && halt_loc == 12'hFE8))
    else $error("no halt after datagram receive");
  AST_HALT_IDLE: assert property (halted |-> !cmd_ready && !host_wr_valid)
    else $error("activity while halted");
  AST_STA_LOAD: assert property (take && op == plce_pkg::OP_WR_STA |-> ##[1:3] pa_wr)
    else $error("station address not loaded");
  AST_LINK_GO: assert property (take && (op == plce_pkg::OP_WR_LINK || op == plce_pkg::OP_RD_LINK) |-> ##[1:3] link_go)
    else $error("link function not started");
endmodule : plce_asserts
bind plce_top plce_asserts #(.N_CNT(N_CNT)) u_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .chan_start(chan_start), .channel_command_word(channel_command_word),
  .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data), .host_wr_ready(host_wr_ready), .link_go(link_go),
  .pa_wr(pa_wr), .cache_wr(cache_wr), .rspq_req(rspq_req), .rspq_ack(rspq_ack), .halted(halted),
  .halt_loc(halt_loc));
`default_nettype wire

// ==== sim/plce_top_tb_top.sv ====
// self-checking bench for the port local command executor
`timescale 1ns/100ps
`default_nettype none
module plce_top_tb_top;
  logic                    clk, rst, cmd_valid, cnt_inc, slow, q_empty, irq, cmd_ready, link_go, link_read;
  logic                    host_wr_valid, host_wr_ready, link_done, cache_wr, cache_flush, rspq_req, rspq_ack;
  logic                    rspq_was_empty, halted;
  logic [5:0]              cnt_idx;
  logic [31:0]             reg_rdata, host_wr_data, link_cmd, link_rdata, seed, got, op, cache_word, exp[$];
  logic [47:0]             pa_addr, sta;
  logic [7:0]              mode_bits, mo;
  logic [3:0]              retry_count;
  logic [11:0]             halt_loc;
  plce_pkg::plce_reg_req_t reg_req;
  plce_pkg::plce_cmd_t     cmd;
  int                      error_cnt = 0, n_tests = 0, nfl, ncw, ix, ecnt[44];

  plce_top dut (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .cnt_inc(cnt_inc), .cnt_idx(cnt_idx),
    .chan_start(), .channel_command_word(), .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data),
    .host_wr_ready(host_wr_ready), .link_go(link_go), .link_read(link_read), .link_cmd(link_cmd),
    .link_done(link_done), .link_rdata(link_rdata), .pa_wr(), .pa_addr(pa_addr), .mode_bits(mode_bits),
    .retry_count(retry_count), .cache_wr(cache_wr), .cache_word(cache_word), .cache_flush(cache_flush),
    .rspq_req(rspq_req), .rspq_ack(rspq_ack), .rspq_was_empty(rspq_was_empty), .halted(halted),
    .halt_loc(halt_loc));
  plce_host_model hm (.clk(clk), .rst(rst), .slow(slow), .q_empty(q_empty), .wr_valid(host_wr_valid),
    .wr_data(host_wr_data), .wr_ready(host_wr_ready), .go(link_go), .lcmd(link_cmd), .done(link_done),
    .rdata(link_rdata), .req(rspq_req), .ack(rspq_ack), .was_empty(rspq_was_empty));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] mk(input logic [7:0] o, input bit r, input bit c);
    mk = {24'h0, o};
    mk[plce_pkg::RSP_BIT] = r;
    mk[plce_pkg::CLR_BIT] = c;
  endfunction : mk
  function automatic void hdr(input logic [31:0] w);
    exp = '{32'h0, 32'h0, 32'h0, w};
  endfunction : hdr
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cmpw(input int fl, input int cw);
    chk("word count", exp.size(), hm.words.size());
    foreach (exp[i]) chk("host word", exp[i], hm.words[i]);
    chk("flush pulses", fl, nfl);
    chk("cache writes", cw, ncw);
  endtask : cmpw
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic wrdy();
    int k;
    k = 0;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("cmd_ready", 1, cmd_ready);
  endtask : wrdy
  task automatic run(input logic [31:0] w, input bit fin);
    @(posedge clk);
    hm.words.delete();
    nfl = 0;
    ncw = 0;
    cmd.opword <= w;
    cmd_valid <= 1'b1;
    wrdy();
    cmd_valid <= 1'b0;
    if (fin) wrdy();
  endtask : run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cache_flush === 1'b1) nfl++;
    if (cache_wr === 1'b1) ncw++;
  end
  // well past the longest stalled sequence
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    seed = 32'h0000_0034;
    {rst, reg_req, cmd, cmd_valid, cnt_inc, cnt_idx, slow, q_empty} = '1;
    {reg_req, cmd, cmd_valid, cnt_inc, cnt_idx, slow, q_empty} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(plce_pkg::REG_CTRL);
    chk("ctrl reset", plce_pkg::CTRL_RST, got);
    rd(plce_pkg::REG_MASK);
    chk("mask reset", 0, got);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C);
    chk("unmapped", 0, got);
    $display("test registers done");
    // corners first: top counter, an index beyond the set, then random
    for (int k = 0; k < 80; k++) begin
      ix = (k == 0) ? 43 : (k == 1) ? 63 : int'(rnd() % 48);
      @(posedge clk);
      cnt_inc <= 1'b1;
      cnt_idx <= 6'(ix);
      if (ix < 44) ecnt[ix]++;
    end
    @(posedge clk);
    cnt_inc <= 1'b0;
    slow <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      op = mk(plce_pkg::OP_RD_CNT, p[0], p == 0);
      hdr(op);
      foreach (ecnt[i]) exp.push_back(32'(ecnt[i]));
      run(op, 1'b1);
      cmpw(0, 1);
      chk("cache word", op, cache_word);
      foreach (ecnt[i]) ecnt[i] = 0;
    end
    $display("test counters done");
    got = rnd();
    sta = {got[15:0], rnd()};
    mo = got[23:16];
    cmd.sta_addr <= sta;
    cmd.mode <= mo;
    cmd.retry <= 4'hF;
    op = mk(plce_pkg::OP_WR_STA, 1, 0);
    hdr(op);
    exp.push_back({16'h0, sta[47:32]});
    exp.push_back(sta[31:0]);
    run(op, 1'b1);
    cmpw(0, 1);
    chk("station", sta, pa_addr);
    chk("mode", mo, mode_bits);
    chk("retry", 4'hF, retry_count);
    cmd.sta_addr <= ~sta;
    sta = ~sta;
    exp = {};
    run(mk(plce_pkg::OP_WR_STA, 0, 0), 1'b1);
    cmpw(1, 0);
    rd(plce_pkg::REG_STA_LO);
    chk("station low", sta[31:0], got);
    wr(plce_pkg::REG_STATUS, 32'h7);
    q_empty <= 1'b1;
    op = mk(plce_pkg::OP_RD_STA, 0, 0);
    hdr(op);
    exp.push_back({16'h0, sta[47:32]});
    exp.push_back(sta[31:0]);
    exp.push_back({16'h0, mo, plce_pkg::VERSION});
    run(op, 1'b1);
    cmpw(0, 1);
    rd(plce_pkg::REG_STATUS);
    chk("status", 32'h5, got);
    chk("irq masked", 0, irq);
    wr(plce_pkg::REG_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wr(plce_pkg::REG_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    $display("test station done");
    for (int i = 0; i < 4; i++) begin
      got = rnd();
      cmd.link_word <= got;
      op = mk(i[0] ? plce_pkg::OP_RD_LINK : plce_pkg::OP_WR_LINK, i[1], 0);
      exp = {};
      if (i[1]) begin
        hdr(op);
        exp.push_back(i[0] ? got ^ 32'hA5A5_A5A5 : got);
      end
      run(op, 1'b1);
      cmpw(!i[1], i[1]);
      chk("link word", got, link_cmd);
      chk("link read", i[0], link_read);
    end
    exp = {};
    run(mk(8'h3F, 0, 0), 1'b1);
    cmpw(1, 0);
    $display("test link done");
    run(mk(plce_pkg::OP_DG_RCV, 0, 0), 1'b0);
    repeat (4) @(posedge clk);
    chk("halted", 1, halted);
    chk("halt location", plce_pkg::HALT_LOC, halt_loc);
    rd(plce_pkg::REG_STATUS);
    chk("halt status", 1, got[plce_pkg::IRQ_HALT]);
    wr(plce_pkg::REG_CTRL, 32'h3);
    wrdy();
    chk("unhalted", 0, halted);
    $display("test halt done");
    summarize();
  end
endmodule : plce_top_tb_top
`default_nettype wire
